// [core/fps_pkg.sv]
package fps_pkg;

  // apb register byte offsets
  localparam logic [7:0] FPS_OFS_CTRL_STATUS = 8'h00;
  localparam logic [7:0] FPS_OFS_CTRL_CONFIG = 8'h04;
  localparam logic [7:0] FPS_OFS_ECC_STATUS  = 8'h08;
  localparam logic [7:0] FPS_OFS_ECC_CONFIG  = 8'h0c;
  localparam logic [7:0] FPS_OFS_MAIN_PROT   = 8'h10;
  localparam logic [7:0] FPS_OFS_EE_PROT     = 8'h14;
  localparam logic [7:0] FPS_OFS_SECURITY    = 8'h18;
  localparam logic [7:0] FPS_OFS_IRQ_STATUS  = 8'h1c;
  localparam logic [7:0] FPS_OFS_IRQ_MASK    = 8'h20;

  // field positions
  localparam int FPS_BIT_CCF    = 7;  // ctrl status: command complete (read only)
  localparam int FPS_BIT_PVIOL  = 4;  // ctrl status: protection violation (w1c)
  localparam int FPS_BIT_CMD_COMPLETE_IRQ_EN   = 7;  // ctrl config
  localparam int FPS_BIT_DFAULT = 1;  // ecc status / config
  localparam int FPS_BIT_SFAULT = 0;
  localparam int FPS_EVT_CC     = 0;  // irq status / mask layout
  localparam int FPS_EVT_DF     = 1;
  localparam int FPS_EVT_SF     = 2;
  localparam int FPS_EVT_PV     = 3;
  localparam int FPS_NEVT       = 4;

  // configuration field addresses
  localparam logic [15:0] FPS_CFG_KEY_LO  = 16'h0400;
  localparam logic [15:0] FPS_CFG_KEY_HI  = 16'h0407;
  localparam logic [15:0] FPS_CFG_RSV_LO  = 16'h0408;
  localparam logic [15:0] FPS_CFG_RSV_HI  = 16'h040b;
  localparam logic [15:0] FPS_CFG_EE_PROT = 16'h040c;
  localparam logic [15:0] FPS_CFG_FL_PROT = 16'h040d;
  localparam logic [15:0] FPS_CFG_SEC     = 16'h040e;
  localparam logic [15:0] FPS_CFG_NVOPT   = 16'h040f;

  // flash and eeprom region bounds
  localparam logic [15:0] FPS_FLASH_TOP   = 16'h7fff;
  localparam logic [15:0] FPS_HIGH_BASE1K = 16'h0400;  // 1 KB, doubled per size step
  localparam logic [15:0] FPS_LOW_BASE2K  = 16'h0800;  // 2 KB, doubled per size step
  localparam logic [8:0]  FPS_EE_STEP     = 9'h020;    // 32 bytes per size step

  // scenario index 7 = no protection; row = from, bit = to
  localparam logic [2:0] FPS_SCN_NONE = 3'h7;
  localparam logic [7:0] FPS_ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  // reset values before the configuration load, and reserved-bit masks
  localparam logic [7:0] FPS_RST_PROT = 8'h00;
  localparam logic [7:0] FPS_RST_SEC  = 8'h00;
  localparam logic [7:0] FPS_MASK_FL  = 8'hbf;  // bit 6 reserved
  localparam logic [7:0] FPS_MASK_EE  = 8'h87;  // bits 6:3 reserved

  typedef struct packed {
    logic       protect_open_bit;
    logic       rsv;
    logic       high_range_disable;
    logic [1:0] high_range_size;
    logic       low_range_disable;
    logic [1:0] low_range_size;
  } fps_main_protect_reg_s;

  typedef struct packed {
    logic       eeprom_protect_open;
    logic [3:0] rsv;
    logic [2:0] eeprom_protect_size;
  } fps_eprot_s;

  typedef struct packed {
    logic        valid;
    logic        is_eeprom;
    logic [15:0] addr;
  } fps_cmd_s;

  typedef enum logic [1:0] {ST_LD_EE, ST_LD_FL, ST_LD_SEC, ST_RUN} fps_load_e;

endpackage : fps_pkg

// [core/fps_core.sv]
`timescale 1ns/1ps
module fps_core
  import fps_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             nvm_rd,
  output logic      [15:0] nvm_addr,
  input  wire logic        nvm_rvalid,
  input  wire logic [7:0]  nvm_rdata,
  input  wire logic        cmd_complete_flag,
  input  wire logic        ecc_double_evt,
  input  wire logic        ecc_single_evt,
  input  wire fps_cmd_s    cmd_req,
  output logic             cmd_grant,
  output logic             cmd_reject,
  output logic             cfg_loaded,
  output logic      [7:0]  sec_state,
  output logic             cmd_irq,
  output logic             err_irq,
  output logic             irq
);

  fps_load_e                ld_state;
  fps_main_protect_reg_s               main_protect_reg;
  fps_eprot_s               eeprom_protect_reg;
  logic       [7:0]         security_reg;
  logic                     cmd_complete_irq_en;
  logic                     double_fault_flag;
  logic                     single_fault_flag;
  logic                     double_fault_irq_en;
  logic                     single_fault_irq_en;
  logic                     prot_viol_flag;
  logic [FPS_NEVT-1:0]      irq_status;
  logic [FPS_NEVT-1:0]      irq_mask;
  logic                     ccf_prev;
  logic                     apb_wr;
  logic                     apb_rd;
  logic                     addr_ok;
  logic                     prot_wr_ok;
  logic                     cmd_blocked;
  logic [FPS_NEVT-1:0]      evt;
  logic [31:0]              next_prdata;
  fps_main_protect_reg_s               wr_main_protect_reg;

  // flash address protected under a given protect setting
  function automatic logic flash_protected(input fps_main_protect_reg_s p, input logic [15:0] a);
    logic [15:0] hi_base;
    logic [15:0] lo_end;
    logic        in_hi;
    logic        in_lo;
    logic        sel;
    hi_base = FPS_FLASH_TOP + 16'h0001 - (FPS_HIGH_BASE1K << p.high_range_size);
    lo_end  = (FPS_LOW_BASE2K << p.low_range_size) - 16'h0001;
    in_hi   = (a >= hi_base) && (a <= FPS_FLASH_TOP);
    in_lo   = (a <= lo_end);
    sel     = (!p.high_range_disable && in_hi) || (!p.low_range_disable && in_lo);
    return p.protect_open_bit ? sel : !sel;
  endfunction : flash_protected

  // eeprom address protected while the open bit is clear
  function automatic logic eeprom_protected(input fps_eprot_s p, input logic [15:0] a);
    logic [8:0] limit;
    limit = FPS_EE_STEP * ({6'h00, p.eeprom_protect_size} + 9'h001);
    return !p.eeprom_protect_open && ({1'b0, a} < {8'h00, limit});
  endfunction : eeprom_protected

  // scenario index from the three mode bits, 7 is unprotected
  function automatic logic [2:0] scenario(input fps_main_protect_reg_s p);
    return {p.protect_open_bit, p.high_range_disable, p.low_range_disable};
  endfunction : scenario

  // apb decode; one wait state so read data comes from a flop
  assign apb_wr     = psel && penable && pready && pwrite;
  assign apb_rd     = psel && penable && !pready && !pwrite;
  assign wr_main_protect_reg   = fps_main_protect_reg_s'(pwdata[7:0] & FPS_MASK_FL);
  assign prot_wr_ok = FPS_ALLOW[scenario(main_protect_reg)][scenario(wr_main_protect_reg)];

  always_comb begin
    unique case (paddr)
      FPS_OFS_CTRL_STATUS, FPS_OFS_CTRL_CONFIG, FPS_OFS_ECC_STATUS, FPS_OFS_ECC_CONFIG,
      FPS_OFS_MAIN_PROT, FPS_OFS_EE_PROT, FPS_OFS_SECURITY, FPS_OFS_IRQ_STATUS,
      FPS_OFS_IRQ_MASK: addr_ok = 1'b1;
      default:          addr_ok = 1'b0;
    endcase
  end

  // read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      FPS_OFS_CTRL_STATUS: begin
        next_prdata[FPS_BIT_CCF]   = cmd_complete_flag;
        next_prdata[FPS_BIT_PVIOL] = prot_viol_flag;
      end
      FPS_OFS_CTRL_CONFIG: next_prdata[FPS_BIT_CMD_COMPLETE_IRQ_EN] = cmd_complete_irq_en;
      FPS_OFS_ECC_STATUS: begin
        next_prdata[FPS_BIT_DFAULT] = double_fault_flag;
        next_prdata[FPS_BIT_SFAULT] = single_fault_flag;
      end
      FPS_OFS_ECC_CONFIG: begin
        next_prdata[FPS_BIT_DFAULT] = double_fault_irq_en;
        next_prdata[FPS_BIT_SFAULT] = single_fault_irq_en;
      end
      FPS_OFS_MAIN_PROT:   next_prdata[7:0]          = main_protect_reg;
      FPS_OFS_EE_PROT:     next_prdata[7:0]          = eeprom_protect_reg;
      FPS_OFS_SECURITY:    next_prdata[7:0]          = security_reg;
      FPS_OFS_IRQ_STATUS:  next_prdata[FPS_NEVT-1:0] = irq_status;
      FPS_OFS_IRQ_MASK:    next_prdata[FPS_NEVT-1:0] = irq_mask;
      default:             next_prdata = 32'h0000_0000;
    endcase
  end

  // apb handshake: pready rises one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addr_ok;
      if (apb_rd) begin
        prdata <= next_prdata;
      end
    end
  end

  // configuration load sequence, one byte per fetch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ld_state <= ST_LD_EE;
      nvm_addr <= FPS_CFG_EE_PROT;
    end else if (nvm_rvalid) begin
      unique case (ld_state)
        ST_LD_EE: begin
          ld_state <= ST_LD_FL;
          nvm_addr <= FPS_CFG_FL_PROT;
        end
        ST_LD_FL: begin
          ld_state <= ST_LD_SEC;
          nvm_addr <= FPS_CFG_SEC;
        end
        ST_LD_SEC: ld_state <= ST_RUN;
        ST_RUN:    ld_state <= ST_RUN;
      endcase
    end
  end

  assign nvm_rd     = (ld_state != ST_RUN);
  assign cfg_loaded = (ld_state == ST_RUN);

  // flash protect register: reset load, then only allowed scenario writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_protect_reg <= fps_main_protect_reg_s'(FPS_RST_PROT);
    end else if (ld_state == ST_LD_FL && nvm_rvalid) begin
      main_protect_reg <= fps_main_protect_reg_s'(nvm_rdata & FPS_MASK_FL);
    end else if (cfg_loaded && apb_wr && paddr == FPS_OFS_MAIN_PROT && prot_wr_ok) begin
      main_protect_reg <= wr_main_protect_reg;
    end
  end

  // eeprom protect register; only open bit and size are kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eeprom_protect_reg <= fps_eprot_s'(FPS_RST_PROT);
    end else if (ld_state == ST_LD_EE && nvm_rvalid) begin
      eeprom_protect_reg <= fps_eprot_s'(nvm_rdata & FPS_MASK_EE);
    end else if (cfg_loaded && apb_wr && paddr == FPS_OFS_EE_PROT) begin
      eeprom_protect_reg <= fps_eprot_s'(pwdata[7:0] & FPS_MASK_EE);
    end
  end

  // security: loaded once per reset; later flash programming of the byte is not seen here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      security_reg <= FPS_RST_SEC;
    end else if (ld_state == ST_LD_SEC && nvm_rvalid) begin
      security_reg <= nvm_rdata;
    end
  end

  assign sec_state = security_reg;

  // enables written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_complete_irq_en <= 1'b0;
      double_fault_irq_en <= 1'b0;
      single_fault_irq_en <= 1'b0;
      irq_mask            <= '0;
    end else if (apb_wr) begin
      if (paddr == FPS_OFS_CTRL_CONFIG) begin
        cmd_complete_irq_en <= pwdata[FPS_BIT_CMD_COMPLETE_IRQ_EN];
      end
      if (paddr == FPS_OFS_ECC_CONFIG) begin
        double_fault_irq_en <= pwdata[FPS_BIT_DFAULT];
        single_fault_irq_en <= pwdata[FPS_BIT_SFAULT];
      end
      if (paddr == FPS_OFS_IRQ_MASK) begin
        irq_mask <= pwdata[FPS_NEVT-1:0];
      end
    end
  end

  // command access check; commands before the load completes are refused
  assign cmd_blocked = !cfg_loaded ||
                       (cmd_req.is_eeprom ? eeprom_protected(eeprom_protect_reg, cmd_req.addr)
                                          : flash_protected(main_protect_reg, cmd_req.addr));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_grant  <= 1'b0;
      cmd_reject <= 1'b0;
    end else begin
      cmd_grant  <= cmd_req.valid && !cmd_blocked;
      cmd_reject <= cmd_req.valid && cmd_blocked;
    end
  end

  // sticky fault and violation flags, set wins over a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      double_fault_flag <= 1'b0;
      single_fault_flag <= 1'b0;
      prot_viol_flag    <= 1'b0;
    end else begin
      if (ecc_double_evt) begin
        double_fault_flag <= 1'b1;
      end else if (apb_wr && paddr == FPS_OFS_ECC_STATUS && pwdata[FPS_BIT_DFAULT]) begin
        double_fault_flag <= 1'b0;
      end
      if (ecc_single_evt) begin
        single_fault_flag <= 1'b1;
      end else if (apb_wr && paddr == FPS_OFS_ECC_STATUS && pwdata[FPS_BIT_SFAULT]) begin
        single_fault_flag <= 1'b0;
      end
      if (cmd_req.valid && cmd_blocked) begin
        prot_viol_flag <= 1'b1;
      end else if (apb_wr && paddr == FPS_OFS_CTRL_STATUS && pwdata[FPS_BIT_PVIOL]) begin
        prot_viol_flag <= 1'b0;
      end
    end
  end

  // module interrupt requests
  assign cmd_irq = cmd_complete_flag && cmd_complete_irq_en;
  assign err_irq = (double_fault_flag && double_fault_irq_en) ||
                   (single_fault_flag && single_fault_irq_en);

  // event capture: completion edge, faults and violations
  assign evt[FPS_EVT_CC] = cmd_complete_flag && !ccf_prev;
  assign evt[FPS_EVT_DF] = ecc_double_evt;
  assign evt[FPS_EVT_SF] = ecc_single_evt;
  assign evt[FPS_EVT_PV] = cmd_req.valid && cmd_blocked;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccf_prev   <= 1'b1;  // no completion event straight out of reset
      irq_status <= '0;
    end else begin
      ccf_prev <= cmd_complete_flag;
      if (apb_wr && paddr == FPS_OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~pwdata[FPS_NEVT-1:0]) | evt;
      end else begin
        irq_status <= irq_status | evt;
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // checks
  a_cmd_irq_src: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_irq == (cmd_complete_flag && cmd_complete_irq_en))
    else $error("command irq does not follow flag and enable");

  a_err_irq_src: assert property (@(posedge pclk) disable iff (!presetn)
    (double_fault_irq_en && ecc_double_evt && !(apb_wr && paddr == FPS_OFS_ECC_CONFIG)) |=> err_irq)
    else $error("error irq missing after double fault");

  a_fl_load: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_state == ST_LD_FL && nvm_rvalid) |=>
      (main_protect_reg == fps_main_protect_reg_s'($past(nvm_rdata) & FPS_MASK_FL)))
    else $error("flash protect byte not loaded");

  a_ee_load: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_state == ST_LD_EE && nvm_rvalid) |-> nvm_addr == FPS_CFG_EE_PROT ##1
      eeprom_protect_reg == fps_eprot_s'($past(nvm_rdata) & FPS_MASK_EE))
    else $error("eeprom protect byte not loaded");

  a_prot_guard: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg_loaded && apb_wr && paddr == FPS_OFS_MAIN_PROT && !prot_wr_ok) |=> $stable(main_protect_reg))
    else $error("forbidden protection change accepted");

  a_sec_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_state == ST_RUN) |=> $stable(security_reg))
    else $error("security changed after load");

  a_sec_load: assert property (@(posedge pclk) disable iff (!presetn)
    (ld_state == ST_LD_SEC && nvm_rvalid) |-> nvm_addr == FPS_CFG_SEC ##1
      security_reg == $past(nvm_rdata))
    else $error("security byte not loaded");

  a_reject_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_req.valid && cmd_blocked) |=> (cmd_reject && !cmd_grant && prot_viol_flag))
    else $error("protected command not rejected");

  a_full_prot: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_req.valid && !cmd_req.is_eeprom && cfg_loaded &&
     scenario(main_protect_reg) == 3'h3) |=> cmd_reject)
    else $error("fully protected flash accepted a command");

  a_top_prot: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_req.valid && !cmd_req.is_eeprom && cfg_loaded && cmd_req.addr == FPS_FLASH_TOP &&
     scenario(main_protect_reg) == 3'h5) |=> cmd_reject)
    else $error("top of flash not protected by high range");

  a_none_prot: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_req.valid && !cmd_req.is_eeprom && cfg_loaded &&
     scenario(main_protect_reg) == FPS_SCN_NONE) |=> cmd_grant)
    else $error("unprotected flash refused a command");

  a_ee_range: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_req.valid && cmd_req.is_eeprom && cfg_loaded && !eeprom_protect_reg.eeprom_protect_open &&
     cmd_req.addr == 16'h0000) |=> cmd_reject)
    else $error("eeprom base not protected");

endmodule : fps_core

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top
  import fps_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, nvm_rd, nvm_rvalid;
  logic [7:0]  paddr, nvm_rdata, sec_state;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] nvm_addr;
  logic        cmd_complete_flag, ecc_double_evt, ecc_single_evt, cmd_grant, cmd_reject;
  logic        cfg_loaded, cmd_irq, err_irq, irq, er;
  fps_cmd_s    cmd_req;
  int          bad_count, checks_done;
  // allowed targets per starting scenario, bit n = target n
  logic [7:0]  allow_tbl [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};

  always #10 pclk = ~pclk;

  fps_core u_fps_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .nvm_rd(nvm_rd),
    .nvm_addr(nvm_addr), .nvm_rvalid(nvm_rvalid), .nvm_rdata(nvm_rdata), .cmd_complete_flag(cmd_complete_flag),
    .ecc_double_evt(ecc_double_evt), .ecc_single_evt(ecc_single_evt), .cmd_req(cmd_req), .cmd_grant(cmd_grant),
    .cmd_reject(cmd_reject), .cfg_loaded(cfg_loaded), .sec_state(sec_state), .cmd_irq(cmd_irq),
    .err_irq(err_irq), .irq(irq));

  // single verdict point, also reached by any timeout
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      bad_count++;
      $display("Error at %0t: bus answer missing", $time);
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask : rchk

  // reset, then answer the three option byte fetches in order
  task automatic load(input logic [7:0] ee, input logic [7:0] fl, input logic [7:0] sec);
    logic [7:0] b [3];
    b = '{ee, fl, sec};
    presetn    <= 1'b0;
    nvm_rvalid <= 1'b0;
    cmd_req    <= '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      check(nvm_rd, 1);
      check(nvm_addr, 16'h040c + i);
      nvm_rvalid <= 1'b1;
      nvm_rdata  <= b[i];
      @(posedge pclk);
      nvm_rvalid <= 1'b0;
      @(posedge pclk);
    end
    check(cfg_loaded, 1);
    check(nvm_rd, 0);
  endtask : load

  // one command request; verdict comes exactly one cycle later
  task automatic cmd(input logic ee, input logic [15:0] a, input logic rej);
    cmd_req <= '{valid: 1'b1, is_eeprom: ee, addr: a};
    @(posedge pclk);
    cmd_req <= '0;
    @(posedge pclk);
    check(cmd_reject, rej);
    check(cmd_grant, !rej);
  endtask : cmd

  function automatic logic [31:0] scn(input int s);
    return {24'h0, s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
  endfunction : scn

  task automatic t_load();
    load(8'h02, 8'h84, 8'h5a);
    rchk(FPS_OFS_MAIN_PROT, 32'h84);
    rchk(FPS_OFS_EE_PROT, 32'h02);
    rchk(FPS_OFS_SECURITY, 32'h5a);
    check(sec_state, 8'h5a);
    $display("test load done");
  endtask : t_load

  task automatic t_regions();
    logic [15:0] hb, lt;
    cmd(1'b0, 16'h7bff, 1'b0);
    cmd(1'b0, 16'h7c00, 1'b1);
    cmd(1'b0, 16'h7fff, 1'b1);
    cmd(1'b0, 16'h0000, 1'b0);
    rchk(FPS_OFS_CTRL_STATUS, 32'h10);
    // scenario 4 at every size: the inner boundary of both ranges, from each side
    for (int s = 0; s < 4; s++) begin
      wr(FPS_OFS_MAIN_PROT, {24'h0, 3'b100, s[1:0], 1'b0, s[1:0]});
      hb = 16'h8000 - (16'h0400 << s);
      lt = 16'h0800 << s;
      cmd(1'b0, hb, 1'b1);
      cmd(1'b0, hb - 16'h1, 1'b0);
      cmd(1'b0, lt - 16'h1, 1'b1);
      cmd(1'b0, lt, 1'b0);
    end
    wr(FPS_OFS_MAIN_PROT, 32'h24);
    rchk(FPS_OFS_MAIN_PROT, 32'h24);
    cmd(1'b0, 16'h4000, 1'b1);
    for (int s = 0; s < 8; s++) begin
      wr(FPS_OFS_EE_PROT, s);
      lt = 16'h0020 * (s + 1);
      cmd(1'b1, lt - 16'h1, 1'b1);
      cmd(1'b1, lt, 1'b0);
    end
    wr(FPS_OFS_EE_PROT, 32'h80);
    cmd(1'b1, 16'h0000, 1'b0);
    $display("test regions done");
  endtask : t_regions

  task automatic t_irq();
    load(8'h02, 8'ha4, 8'h5a);
    cmd_complete_flag <= 1'b1;
    repeat (2) @(posedge pclk);
    check(cmd_irq, 0);
    wr(FPS_OFS_CTRL_CONFIG, 32'h80);
    check(cmd_irq, 1);
    check(irq, 0);
    wr(FPS_OFS_IRQ_MASK, 32'h0f);
    check(irq, 1);
    wr(FPS_OFS_IRQ_STATUS, 32'h01);
    check(irq, 0);
    wr(FPS_OFS_CTRL_CONFIG, 32'h00);
    check(cmd_irq, 0);
    ecc_double_evt <= 1'b1;
    @(posedge pclk);
    ecc_double_evt <= 1'b0;
    @(posedge pclk);
    rchk(FPS_OFS_ECC_STATUS, 32'h02);
    check(err_irq, 0);
    wr(FPS_OFS_ECC_CONFIG, 32'h02);
    check(err_irq, 1);
    wr(FPS_OFS_ECC_STATUS, 32'h02);
    check(err_irq, 0);
    ecc_double_evt <= 1'b1;
    @(posedge pclk);
    ecc_double_evt <= 1'b0;
    @(posedge pclk);
    check(err_irq, 1);
    wr(FPS_OFS_ECC_CONFIG, 32'h01);
    check(err_irq, 0);
    wr(FPS_OFS_ECC_STATUS, 32'h02);
    ecc_single_evt <= 1'b1;
    @(posedge pclk);
    ecc_single_evt <= 1'b0;
    @(posedge pclk);
    check(err_irq, 1);
    rchk(FPS_OFS_IRQ_STATUS, 32'h06);
    wr(FPS_OFS_ECC_STATUS, 32'h01);
    check(err_irq, 0);
    cmd_complete_flag <= 1'b0;
    $display("test irq done");
  endtask : t_irq

  task automatic t_sec();
    apb(1'b0, 8'h24, 32'h0);
    check(er, 1);
    check(rd, 0);
    wr(FPS_OFS_SECURITY, 32'h00);
    check(sec_state, 8'h5a);
    load(8'h02, 8'ha4, 8'h11);
    check(sec_state, 8'h11);
    $display("test security done");
  endtask : t_sec

  // every from/to pair, each from a fresh load
  task automatic t_trans();
    for (int f = 0; f < 8; f++) begin
      for (int t = 0; t < 8; t++) begin
        load(8'h00, scn(f), 8'h5a);
        wr(FPS_OFS_MAIN_PROT, scn(t));
        rchk(FPS_OFS_MAIN_PROT, allow_tbl[f][t] ? scn(t) : scn(f));
      end
    end
    $display("test transitions done");
  endtask : t_trans

  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge pclk);
    bad_count++;
    $display("Error at %0t: run timeout", $time);
    end_sim();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    nvm_rvalid = 1'b0;
    nvm_rdata = 8'h00;
    cmd_complete_flag = 1'b0;
    ecc_double_evt = 1'b0;
    ecc_single_evt = 1'b0;
    cmd_req = '0;
    t_load();
    t_regions();
    t_irq();
    t_sec();
    t_trans();
    end_sim();
  end
endmodule : tb_top
